// ===== src/dra_chain.sv
// Front-end serial shift chain with its parallel configuration latch
`timescale 1ns/1ps
`include "dra_consts.svh"

module dra_chain (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Host side
    input  wire logic              shift_en,
    input  wire logic              shift_bit,
    input  wire logic              latch_en,
    // Chain and latch contents
    output dra_pkg::dra_chain_t    chain_q,
    output dra_pkg::dra_chain_t    latch_q
);

    // New bit enters at position 0, older bits move toward the output end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= `DRA_RST_CHAIN;
        end else if (shift_en) begin
            chain_q <= {chain_q[`DRA_CHAIN_LEN-2:0], shift_bit};
        end
    end

    // Latch only moves on the strobe, so shifting never glitches the relays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= `DRA_RST_CHAIN;
        end else if (latch_en) begin
            latch_q <= chain_q;
        end
    end

endmodule : dra_chain

// ===== src/dra_consts.svh
// Register offsets, field positions, reset values and chain layout for the range/arm block
`ifndef DRA_CONSTS_SVH
`define DRA_CONSTS_SVH

// Register byte offsets
`define DRA_OFF_SERIAL        8'h05
`define DRA_OFF_STROBE        8'h0B
`define DRA_OFF_ARM_STATUS    8'h43
`define DRA_OFF_ARM_SOURCE    8'h49
`define DRA_OFF_ARM_CONTROL   8'h4B

// Strobe value that copies the chain into the latch
`define DRA_STROBE_VALUE      8'h04

// Field positions
`define DRA_STAT_INIT_BIT     1
`define DRA_CTRL_SUSPEND_BIT  2

// Shift chain geometry
`define DRA_CHAIN_LEN         56
`define DRA_CHAIN_OUT_BIT     55

// Chain bit positions of the attenuator controls
`define DRA_BIT_CH1_PATH_EN   10
`define DRA_BIT_CH2_PATH_EN   15
`define DRA_BIT_CH1_IN20      34
`define DRA_BIT_CH1_POST      35
`define DRA_BIT_CH1_INT6      37
`define DRA_BIT_CH1_INT14     38
`define DRA_BIT_CH2_IN20      42
`define DRA_BIT_CH2_POST      43
`define DRA_BIT_CH2_INT6      45
`define DRA_BIT_CH2_INT14     46

// Reset values
`define DRA_RST_CHAIN         56'h00_0000_0000_0000
`define DRA_RST_ARM_SOURCE    8'h00
`define DRA_RST_ARM_CONTROL   8'h00

`endif

// ===== src/dra_pkg.sv
// Types shared by the range/arm configuration block
package dra_pkg;
    typedef logic [7:0]  dra_byte_t;
    typedef logic [55:0] dra_chain_t;
    typedef enum logic [0:0] {
        DRA_IDLE,
        DRA_INITIATED
    } dra_state_e;
endpackage : dra_pkg

// ===== src/dra_top.sv
// Range and arm configuration registers of a two-channel digitizer
//
// Overview of operation
// - Writing 4 to offset 0B copies the whole chain into the latch.
// - Offset 43 bit 1 reads 0 when idle, 1 when initiated.
// - Writing offset 49 in idle selects the arm source.
// - Arm source changes are accepted idle or initiated with the suspend sequence.
// - Offset 4B bit 2 set makes the device ignore arm events.
// - Clearing offset 4B bit 2 resumes accepting arm events.
// - Reading counts and sample rate come from timebase setup, not these registers.
// - Each write to offset 05 shifts the bit in at 0, out at 55.
// - Attenuator select bits are active low: zero switches the attenuator in.
// - Path-enable bit zero disables channel attenuators, one enables them.
`timescale 1ns/1ps
`include "dra_consts.svh"

module dra_top (
    // Clock and reset
    input  wire logic              MCLK,
    input  wire logic              RSTN,
    // Register port
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic [7:0]        REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic [7:0]             REG_RDATA,
    // Timebase state inputs, asynchronous
    input  wire logic              INIT_REQ,
    input  wire logic              ABORT_REQ,
    // Arm events from the selected sources, asynchronous
    input  wire logic [7:0]        ARM_EVENT_IN,
    // Arm outputs
    output logic                   ARM_OUT,
    output logic [7:0]             ARM_SOURCE,
    // Live front-end controls
    output logic                   CH1_ATTEN_PATH_EN,
    output logic                   CH2_ATTEN_PATH_EN,
    output logic                   CH1_INPUT_20DB_IN,
    output logic                   CH1_POST_20DB_IN,
    output logic                   CH1_INT_6DB_IN,
    output logic                   CH1_INT_14DB_IN,
    output logic                   CH2_INPUT_20DB_IN,
    output logic                   CH2_POST_20DB_IN,
    output logic                   CH2_INT_6DB_IN,
    output logic                   CH2_INT_14DB_IN,
    output logic [55:0]            FE_LATCH,
    output logic [7:0]             SERIAL_OUT
);

    dra_pkg::dra_chain_t  chain_q;
    dra_pkg::dra_chain_t  latch_q;
    dra_pkg::dra_byte_t   arm_source_q;
    dra_pkg::dra_byte_t   arm_control_q;
    dra_pkg::dra_state_e  state_q;
    logic [1:0]           init_sync_q;
    logic [1:0]           abort_sync_q;
    logic [7:0]           arm_sync0_q;
    logic [7:0]           arm_sync1_q;
    logic [7:0]           arm_prev_q;
    logic                 suspended;
    logic                 arm_hit;
    logic                 wr_serial;
    logic                 wr_strobe;
    logic                 wr_source;
    logic                 wr_control;

    // Address match used by every write decode and the read mux
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    // Write strobes
    assign wr_serial  = REG_WR && hit(REG_ADDR, `DRA_OFF_SERIAL);
    assign wr_strobe  = REG_WR && hit(REG_ADDR, `DRA_OFF_STROBE)
                        && (REG_WDATA == `DRA_STROBE_VALUE);
    assign wr_source  = REG_WR && hit(REG_ADDR, `DRA_OFF_ARM_SOURCE);
    assign wr_control = REG_WR && hit(REG_ADDR, `DRA_OFF_ARM_CONTROL);

    // Shift chain and latch; other strobe values are ignored
    dra_chain u_chain (
        .clk       (MCLK),
        .rst_n     (RSTN),
        .shift_en  (wr_serial),
        .shift_bit (REG_WDATA[0]),
        .latch_en  (wr_strobe),
        .chain_q   (chain_q),
        .latch_q   (latch_q)
    );

    // Asynchronous pin inputs pass two flops before any logic reads them
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            init_sync_q  <= 2'h0;
            abort_sync_q <= 2'h0;
            arm_sync0_q  <= 8'h00;
            arm_sync1_q  <= 8'h00;
        end else begin
            init_sync_q  <= {init_sync_q[0], INIT_REQ};
            abort_sync_q <= {abort_sync_q[0], ABORT_REQ};
            arm_sync0_q  <= ARM_EVENT_IN;
            arm_sync1_q  <= arm_sync0_q;
        end
    end

    // Previous synchronised arm level for rising-edge detection
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            arm_prev_q <= 8'h00;
        end else begin
            arm_prev_q <= arm_sync1_q;
        end
    end

    // Idle/initiated state; abort wins, an arm returns the device to idle
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= dra_pkg::DRA_IDLE;
        end else begin
            unique case (state_q)
                dra_pkg::DRA_IDLE: begin
                    if (init_sync_q[1] && !abort_sync_q[1]) begin
                        state_q <= dra_pkg::DRA_INITIATED;
                    end
                end
                dra_pkg::DRA_INITIATED: begin
                    if (abort_sync_q[1] || arm_hit) begin
                        state_q <= dra_pkg::DRA_IDLE;
                    end
                end
            endcase
        end
    end

    // Arm source accepted in either state; the host suspends first when initiated
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            arm_source_q <= `DRA_RST_ARM_SOURCE;
        end else if (wr_source) begin
            arm_source_q <= REG_WDATA;
        end
    end

    // Arm control holds every written bit for read-modify-write
    // Reading counts and sample rate belong to timebase setup, so none live here
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            arm_control_q <= `DRA_RST_ARM_CONTROL;
        end else if (wr_control) begin
            arm_control_q <= REG_WDATA;
        end
    end

    // Suspend gates arm events; a source swap mid-run cannot fire a stray arm
    assign suspended = arm_control_q[`DRA_CTRL_SUSPEND_BIT];
    assign arm_hit   = (state_q == dra_pkg::DRA_INITIATED) && !suspended
                       && |(arm_source_q & arm_sync1_q & ~arm_prev_q);

    // Arm pulse, one cycle per accepted event
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ARM_OUT <= 1'b0;
        end else begin
            ARM_OUT <= arm_hit;
        end
    end

    // Registered read data; unmapped and write-only offsets read zero
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            if (hit(REG_ADDR, `DRA_OFF_ARM_STATUS)) begin
                REG_RDATA <= {6'h00, state_q == dra_pkg::DRA_INITIATED, 1'b0};
            end else if (hit(REG_ADDR, `DRA_OFF_ARM_SOURCE)) begin
                REG_RDATA <= arm_source_q;
            end else if (hit(REG_ADDR, `DRA_OFF_ARM_CONTROL)) begin
                REG_RDATA <= arm_control_q;
            end else if (hit(REG_ADDR, `DRA_OFF_SERIAL)) begin
                REG_RDATA <= {7'h00, chain_q[`DRA_CHAIN_OUT_BIT]};
            end else begin
                REG_RDATA <= 8'h00;
            end
        end
    end

    // Front-end drive from the latch; select bits are active low
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            CH1_ATTEN_PATH_EN <= 1'b0;
            CH2_ATTEN_PATH_EN <= 1'b0;
            CH1_INPUT_20DB_IN <= 1'b0;
            CH1_POST_20DB_IN  <= 1'b0;
            CH1_INT_6DB_IN    <= 1'b0;
            CH1_INT_14DB_IN   <= 1'b0;
            CH2_INPUT_20DB_IN <= 1'b0;
            CH2_POST_20DB_IN  <= 1'b0;
            CH2_INT_6DB_IN    <= 1'b0;
            CH2_INT_14DB_IN   <= 1'b0;
        end else begin
            CH1_ATTEN_PATH_EN <= latch_q[`DRA_BIT_CH1_PATH_EN];
            CH2_ATTEN_PATH_EN <= latch_q[`DRA_BIT_CH2_PATH_EN];
            // Path disabled forces every attenuator of that channel out
            CH1_INPUT_20DB_IN <= latch_q[`DRA_BIT_CH1_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH1_IN20];
            CH1_POST_20DB_IN  <= latch_q[`DRA_BIT_CH1_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH1_POST];
            CH1_INT_6DB_IN    <= latch_q[`DRA_BIT_CH1_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH1_INT6];
            CH1_INT_14DB_IN   <= latch_q[`DRA_BIT_CH1_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH1_INT14];
            CH2_INPUT_20DB_IN <= latch_q[`DRA_BIT_CH2_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH2_IN20];
            CH2_POST_20DB_IN  <= latch_q[`DRA_BIT_CH2_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH2_POST];
            CH2_INT_6DB_IN    <= latch_q[`DRA_BIT_CH2_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH2_INT6];
            CH2_INT_14DB_IN   <= latch_q[`DRA_BIT_CH2_PATH_EN]
                                 && !latch_q[`DRA_BIT_CH2_INT14];
        end
    end

    // Raw latch, arm source and chain output copies for the rest of the front end
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            FE_LATCH   <= `DRA_RST_CHAIN;
            ARM_SOURCE <= `DRA_RST_ARM_SOURCE;
            SERIAL_OUT <= 8'h00;
        end else begin
            FE_LATCH   <= latch_q;
            ARM_SOURCE <= arm_source_q;
            SERIAL_OUT <= {7'h00, chain_q[`DRA_CHAIN_OUT_BIT]};
        end
    end

endmodule : dra_top

// ===== test/dra_host.sv
// Host model driving the register port of the range/arm block
`timescale 1ns/1ps
module dra_host (
    // Clock
    input  wire logic  mclk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd
);
    // One access per call; idle bus shows inverted values so stale data is never trusted
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge mclk);
        #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
        @(posedge mclk);
        #1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
    endtask : acc
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
endmodule : dra_host

// ===== test/dra_top_sva.sv
// Port checker for the range/arm block, bound to its top
`timescale 1ns/1ps
`include "dra_consts.svh"
module dra_top_sva (
    // Clock, reset, register port
    input wire logic        MCLK,
    input wire logic        RSTN,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [7:0]  REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_RDATA,
    // Arm side
    input wire logic        ABORT_REQ,
    input wire logic        ARM_OUT,
    input wire logic [7:0]  ARM_SOURCE,
    // Front-end side
    input wire logic        CH1_ATTEN_PATH_EN,
    input wire logic        CH1_INPUT_20DB_IN,
    input wire logic        CH1_POST_20DB_IN,
    input wire logic        CH1_INT_6DB_IN,
    input wire logic        CH1_INT_14DB_IN,
    input wire logic [55:0] FE_LATCH,
    input wire logic [7:0]  SERIAL_OUT
);
    logic strb;
    logic susp_q;
    // Only the exact strobe value may move the latch
    assign strb = REG_WR && REG_ADDR == `DRA_OFF_STROBE && REG_WDATA == `DRA_STROBE_VALUE;
    // Shadow of the suspend bit, kept so the arm gate can be judged
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) susp_q <= 1'b0;
        else if (REG_WR && REG_ADDR == `DRA_OFF_ARM_CONTROL) susp_q <= REG_WDATA[2];
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    latch_hold_a: assert property ($changed(FE_LATCH) |-> $past(strb, 2))
        else $error("latch changed without strobe");
    serial_out_a: assert property (SERIAL_OUT[7:1] == 7'h00
        && (!$changed(SERIAL_OUT) || $past(REG_WR && REG_ADDR == `DRA_OFF_SERIAL, 2)))
        else $error("serial out bad");
    idle_status_a: assert property (ABORT_REQ [*5]
        ##0 (REG_RD && REG_ADDR == `DRA_OFF_ARM_STATUS) |=> REG_RDATA == 8'h00)
        else $error("status not idle after abort");
    ctrl_back_a: assert property (REG_WR && REG_ADDR == `DRA_OFF_ARM_CONTROL ##2 REG_RD
        && REG_ADDR == `DRA_OFF_ARM_CONTROL |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("arm control readback wrong");
    src_copy_a: assert property (REG_WR && REG_ADDR == `DRA_OFF_ARM_SOURCE
        |-> ##2 ARM_SOURCE == $past(REG_WDATA, 2)) else $error("arm source not adopted");
    arm_gate_a: assert property (ARM_OUT |-> !$past(susp_q) && ARM_SOURCE != 8'h00)
        else $error("arm accepted while suspended");
    arm_pulse_a: assert property (ARM_OUT |=> !ARM_OUT) else $error("arm pulse too long");
    ch1_atten_a: assert property (CH1_ATTEN_PATH_EN == FE_LATCH[10]
        && {CH1_INPUT_20DB_IN, CH1_POST_20DB_IN, CH1_INT_6DB_IN, CH1_INT_14DB_IN}
        == ({4{FE_LATCH[10]}} & ~{FE_LATCH[34], FE_LATCH[35], FE_LATCH[37], FE_LATCH[38]}))
        else $error("ch1 attenuator pins wrong");
endmodule : dra_top_sva

bind dra_top dra_top_sva u_sva (
    .MCLK(MCLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ABORT_REQ(ABORT_REQ), .ARM_OUT(ARM_OUT),
    .ARM_SOURCE(ARM_SOURCE), .CH1_ATTEN_PATH_EN(CH1_ATTEN_PATH_EN),
    .CH1_INPUT_20DB_IN(CH1_INPUT_20DB_IN), .CH1_POST_20DB_IN(CH1_POST_20DB_IN),
    .CH1_INT_6DB_IN(CH1_INT_6DB_IN), .CH1_INT_14DB_IN(CH1_INT_14DB_IN),
    .FE_LATCH(FE_LATCH), .SERIAL_OUT(SERIAL_OUT));

// ===== test/dra_top_tb.sv
// Self-checking bench for the range/arm block
`timescale 1ns/1ps
`include "dra_consts.svh"
module dra_top_tb;
    logic        mclk = 1'b0;
    logic        rstn, init_req, abort_req, wr, rd, arm_out, b, p1;
    logic [7:0]  arm_ev, addr, wdata, rdata, src, sout;
    logic [9:0]  att;
    logic [55:0] fe, chn, lat;
    logic [7:0]  exp_q[$];
    logic [7:0]  ra [5] = '{8'h43, 8'h49, 8'h4b, 8'h0b, 8'h20};
    integer      seed;
    int          err_total, num_checks;
    always #20 mclk = ~mclk;
    dra_top dut (
        .MCLK(mclk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .INIT_REQ(init_req), .ABORT_REQ(abort_req), .ARM_EVENT_IN(arm_ev),
        .ARM_OUT(arm_out), .ARM_SOURCE(src), .CH1_ATTEN_PATH_EN(att[9]),
        .CH2_ATTEN_PATH_EN(att[8]), .CH1_INPUT_20DB_IN(att[7]), .CH1_POST_20DB_IN(att[6]),
        .CH1_INT_6DB_IN(att[5]), .CH1_INT_14DB_IN(att[4]), .CH2_INPUT_20DB_IN(att[3]),
        .CH2_POST_20DB_IN(att[2]), .CH2_INT_6DB_IN(att[1]), .CH2_INT_14DB_IN(att[0]),
        .FE_LATCH(fe), .SERIAL_OUT(sout));
    dra_host host (.mclk(mclk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
    // Attenuator pins from a latch image; a disabled path forces all out
    function automatic logic [9:0] att_of(input logic [55:0] f);
        return {f[10], f[15], {4{f[10]}} & ~{f[34], f[35], f[37], f[38]},
                {4{f[15]}} & ~{f[42], f[43], f[45], f[46]}};
    endfunction : att_of
    task automatic cmp(input logic [55:0] got, input logic [55:0] want);
        num_checks++;
        if (got !== want) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask : cmp
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.acc(a, 8'h00, 1'b0);
    endtask : rdx
    // Rising edge on arm lines, arm pulses counted over a bounded window
    task automatic pulse(input logic [7:0] ln, input logic [1:0] want);
        logic [1:0] seen;
        seen = 2'h0;
        @(posedge mclk);
        #1 arm_ev = ln;
        repeat (8) begin
            @(posedge mclk);
            #1 if (arm_out === 1'b1) seen++;
        end
        arm_ev = 8'h00;
        cmp({54'h0, seen}, {54'h0, want});
    endtask : pulse
    // Read data stands from the edge after the strobe; checked mid-cycle
    always @(negedge mclk) begin
        if (p1) cmp({48'h0, rdata}, {48'h0, exp_q.pop_front()});
        p1 = rd;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude();
    end
    initial begin
        {rstn, init_req, abort_req, arm_ev} = 11'h0;
        {seed, lat, chn} = {32'hf960, 112'h0};
        repeat (16) @(posedge mclk);
        #1 rstn = 1'b1;
        // Reset values; status ignores writes, strobe and unmapped places read zero
        host.acc(`DRA_OFF_ARM_STATUS, 8'hff, 1'b1);
        foreach (ra[i]) rdx(ra[i], 8'h00);
        cmp({46'h0, att}, 56'h0);
        $display("test reset done");
        // Two full chain passes: paths enabled, then disabled
        for (int r = 0; r < 2; r++) begin
            for (int k = 55; k >= 0; k--) begin
                b = (k == 10 || k == 15) ? (r == 0) : 1'($random(seed));
                chn = {chn[54:0], b};
                host.acc(`DRA_OFF_SERIAL, {7'h0, b}, 1'b1);
            end
            rdx(`DRA_OFF_SERIAL, {7'h0, chn[55]});
            cmp({48'h0, sout}, {55'h0, chn[55]});
            host.acc(`DRA_OFF_STROBE, 8'h05, 1'b1);
            @(posedge mclk);
            #1 cmp(fe, lat);
            host.acc(`DRA_OFF_STROBE, `DRA_STROBE_VALUE, 1'b1);
            @(posedge mclk);
            #1 lat = chn;
            cmp(fe, lat);
            cmp({46'h0, att}, {46'h0, att_of(lat)});
        end
        $display("test chain done");
        // Idle source select, then a suspended source swap while initiated
        host.acc(`DRA_OFF_ARM_SOURCE, 8'h01, 1'b1);
        host.acc(`DRA_OFF_ARM_CONTROL, 8'h81, 1'b1);
        rdx(`DRA_OFF_ARM_CONTROL, 8'h81);
        rdx(`DRA_OFF_ARM_SOURCE, 8'h01);
        init_req = 1'b1;
        repeat (4) @(posedge mclk);
        #1 init_req = 1'b0;
        rdx(`DRA_OFF_ARM_STATUS, 8'h02);
        host.acc(`DRA_OFF_ARM_CONTROL, 8'h85, 1'b1);
        pulse(8'h01, 2'd0);
        host.acc(`DRA_OFF_ARM_SOURCE, 8'h02, 1'b1);
        host.acc(`DRA_OFF_ARM_CONTROL, 8'h81, 1'b1);
        cmp({48'h0, src}, 56'h02);
        pulse(8'h01, 2'd0);
        pulse(8'h02, 2'd1);
        rdx(`DRA_OFF_ARM_STATUS, 8'h00);
        pulse(8'h02, 2'd0);
        $display("test arm done");
        // Abort from initiated, held against a standing initiate request
        init_req = 1'b1;
        repeat (4) @(posedge mclk);
        rdx(`DRA_OFF_ARM_STATUS, 8'h02);
        abort_req = 1'b1;
        repeat (6) @(posedge mclk);
        rdx(`DRA_OFF_ARM_STATUS, 8'h00);
        {init_req, abort_req} = 2'b00;
        $display("test abort done");
        repeat (4) @(posedge mclk);
        conclude();
    end
endmodule : dra_top_tb
